// ---- core/haptic_pkg.sv ----
// Shared constants and types for the haptic playback trigger control block.
package haptic_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned STEP_SLOW_US = 5000;
	localparam int unsigned STEP_FAST_US = 1000;
	localparam int unsigned WDOG_NS = 4330000;
	localparam int unsigned OC_CHECK_US = 100;
	localparam int unsigned STEP_SLOW_CYC = STEP_SLOW_US * CLK_MHZ;
	localparam int unsigned STEP_FAST_CYC = STEP_FAST_US * CLK_MHZ;
	localparam int unsigned WDOG_CYC = WDOG_NS / 1000 * CLK_MHZ;
	localparam int unsigned OC_CHECK_CYC = OC_CHECK_US * CLK_MHZ;
	localparam int unsigned CNT_W = 24;
	// ------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_FIRE = 8'h08;
	localparam logic [7:0] OFF_OFFS = 8'h0C;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	localparam logic [7:0] OFF_RTP = 8'h14;
	localparam logic [7:0] OFF_SUPPLY = 8'h18;
	localparam int unsigned ST_OT_BIT = 0;
	localparam int unsigned ST_OC_BIT = 1;
	localparam int unsigned ST_PLAY_BIT = 2;
	localparam int unsigned MD_STANDBY_BIT = 3;
	localparam int unsigned CT_FAST_BIT = 0;
	localparam int unsigned CT_OL_BIT = 1;
	localparam int unsigned CT_NG_LSB = 2;
	localparam int unsigned CT_PER_LSB = 8;
	localparam logic [3:0] MODE_RST = 4'h8;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [31:0] OFFS_RST = 32'h0000_0000;
	localparam logic [7:0] RTP_RST = 8'h00;
	localparam logic [3:0] SYNC_RST = 4'h8;
	localparam logic [7:0] NG_STEP = 8'h10;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_TRIG_SOFT = 3'h0,
		MODE_TRIG_EDGE = 3'h1,
		MODE_TRIG_LEVEL = 3'h2,
		MODE_PWM_IN = 3'h3,
		MODE_RTP = 3'h5
	} mode_e;
	typedef enum logic [1:0] {
		PLAY_IDLE = 2'h0,
		PLAY_FETCH = 2'h1,
		PLAY_HOLD = 2'h3
	} play_e;
	typedef struct packed {
		logic signed [7:0] amp;
		logic [7:0] dur;
		logic ramp;
		logic last;
		logic signed [7:0] peak_pos;
		logic signed [7:0] peak_neg;
	} lib_step_s;
	typedef struct packed {
		logic active;
		logic [7:0] amp;
		logic open_loop;
		logic [6:0] period;
	} drive_s;
endpackage

// ---- core/haptic_playback_trigger_control.sv ----
// Trigger, playback timing and protection control of a haptic driver.
// What this block does
// R1 - Offsets touch library waveforms only
// R2 - Signed 8-bit offsets added to step times
// R3 - Peak positive is overdrive, peak negative brake
// R4 - Offsets apply to holds and stretched ramps
// R5 - Steps advance every 5 ms or 1 ms
// R6 - Real-time register drives playback directly
// R7 - Real-time amplitude plays until standby or mode change
// R8 - Open-loop select drives at programmed period
// R9 - Continuous modes drive on entry, stop on exit
// R10 - Fire bit write launches, clear cancels
// R11 - Trigger rising edge sets fire bit
// R12 - Second rising edge while firing cancels
// R13 - Trigger falling edge does nothing in edge mode
// R14 - Host holds edge pulse at least 1 us
// R15 - Level mode fire bit follows trigger pin
// R16 - Host holds level high for whole waveform
// R17 - Noise gate suppresses small input levels
// R18 - Supply voltage captured during playback
// R19 - Serial engine watchdog 4.33 ms outside standby
// R20 - Over-temperature shuts down and flags
// R21 - Overcurrent latches, shuts down, retries, restarts
// R22 - Brownout returns everything to defaults
// R23 - Trigger pin synchronised before detection
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module haptic_playback_trigger_control
#(
	parameter int unsigned STEP_SLOW_CYC = haptic_pkg::STEP_SLOW_CYC,
	parameter int unsigned STEP_FAST_CYC = haptic_pkg::STEP_FAST_CYC,
	parameter int unsigned WDOG_CYC = haptic_pkg::WDOG_CYC,
	parameter int unsigned OC_CHECK_CYC = haptic_pkg::OC_CHECK_CYC
)
(
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous pins.
	input wire logic input_trigger_pin,
	input wire logic over_temp_pin,
	input wire logic short_detect_pin,
	input wire logic brownout_n_pin,
	// Library waveform steps.
	input wire logic lib_valid,
	input haptic_pkg::lib_step_s lib_step,
	output logic lib_ready,
	output logic seq_start,
	// Front end and supply monitor.
	input wire logic [7:0] pwm_level,
	input wire logic [7:0] supply_code,
	input wire logic supply_valid,
	// Serial engine watchdog.
	input wire logic serial_busy,
	input wire logic serial_activity,
	output logic serial_engine_reset,
	// Drive engine.
	output haptic_pkg::drive_s drive,
	output logic shutdown
);
	localparam int unsigned CW = haptic_pkg::CNT_W;
	localparam longint unsigned CNT_MAX = 64'd1 << CW;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (STEP_FAST_CYC < 1 || STEP_SLOW_CYC < 1 || WDOG_CYC < 1 ||
		OC_CHECK_CYC < 1 || STEP_SLOW_CYC >= CNT_MAX ||
		STEP_FAST_CYC >= CNT_MAX || WDOG_CYC >= CNT_MAX ||
		OC_CHECK_CYC >= CNT_MAX)
	begin : bad_count
		$error("Cycle counts must be at least one and fit the counters.");
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic trig_d_reg;
	wire [3:0] pins_raw = {brownout_n_pin, short_detect_pin,
		over_temp_pin, input_trigger_pin};

	// Only the second stage is read by logic. [R23]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= haptic_pkg::SYNC_RST;
			sync2_reg <= haptic_pkg::SYNC_RST;
			trig_d_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			trig_d_reg <= sync2_reg[0];
		end
	end

	wire trig_s = sync2_reg[0];
	wire ot_s = sync2_reg[1];
	wire short_s = sync2_reg[2];
	wire brown = ~sync2_reg[3]; // [R22]
	wire trig_rise = trig_s & ~trig_d_reg;
	wire trig_fall = ~trig_s & trig_d_reg;

	// ------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------
	logic [3:0] mode_reg;
	logic [31:0] offs_reg;
	logic [15:0] ctrl_reg;
	logic [7:0] rtp_reg;
	logic [7:0] supply_reg;
	logic fire_reg;
	logic fire_d_reg;
	logic ot_reg;
	logic oc_reg;
	logic oc_hold_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_word;
	haptic_pkg::play_e state_reg;
	haptic_pkg::drive_s drive_reg;

	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire hit_st = paddr == haptic_pkg::OFF_STATUS;
	wire hit_md = paddr == haptic_pkg::OFF_MODE;
	wire hit_fi = paddr == haptic_pkg::OFF_FIRE;
	wire hit_of = paddr == haptic_pkg::OFF_OFFS;
	wire hit_ct = paddr == haptic_pkg::OFF_CTRL;
	wire hit_rt = paddr == haptic_pkg::OFF_RTP;
	wire hit_su = paddr == haptic_pkg::OFF_SUPPLY;
	wire mapped = hit_st | hit_md | hit_fi | hit_of | hit_ct | hit_rt |
		hit_su;
	wire st_w1c_ot = wr & hit_st & pwdata[haptic_pkg::ST_OT_BIT];
	wire st_w1c_oc = wr & hit_st & pwdata[haptic_pkg::ST_OC_BIT];
	wire fire_wr = wr & hit_fi;
	assign pready = penable;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_reg;

	// Read data is captured in the setup cycle so it comes from a flop.
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit_st)
		begin
			rd_word[haptic_pkg::ST_OT_BIT] = ot_reg; // [R20]
			rd_word[haptic_pkg::ST_OC_BIT] = oc_reg; // [R21]
			rd_word[haptic_pkg::ST_PLAY_BIT] = drive_reg.active;
		end
		if (hit_md)
			rd_word[3:0] = mode_reg;
		if (hit_fi)
			rd_word[0] = fire_reg;
		if (hit_of)
			rd_word = offs_reg;
		if (hit_ct)
			rd_word[15:0] = ctrl_reg;
		if (hit_rt)
			rd_word[7:0] = rtp_reg;
		if (hit_su)
			rd_word[7:0] = supply_reg; // [R18]
	end

	// ------------------------------------------------------------
	// Mode decode and protection
	// ------------------------------------------------------------
	wire standby = mode_reg[haptic_pkg::MD_STANDBY_BIT];
	wire [2:0] mode_sel = mode_reg[2:0];
	wire m_edge = mode_sel == haptic_pkg::MODE_TRIG_EDGE;
	wire m_level = mode_sel == haptic_pkg::MODE_TRIG_LEVEL;
	wire m_rtp = mode_sel == haptic_pkg::MODE_RTP;
	wire m_pwm = mode_sel == haptic_pkg::MODE_PWM_IN;
	wire m_lib = m_edge | m_level | (mode_sel == haptic_pkg::MODE_TRIG_SOFT);
	logic [CW-1:0] oc_cnt_reg;
	wire oc_chk = oc_hold_reg &
		(oc_cnt_reg == CW'(OC_CHECK_CYC - 1));
	// A short is only seen while the output is actually driving. [R21]
	wire oc_event = short_s & drive_reg.active;
	wire oc_restore = oc_chk & ~short_s; // [R21]
	wire ctl_clr = brown | oc_restore; // [R22]
	assign shutdown = ot_s | oc_hold_reg; // [R20]
	wire halt = standby | shutdown | ctl_clr;

	// Flags are sticky, cleared by writing one; a new event wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ot_reg <= 1'b0;
			oc_reg <= 1'b0;
			oc_hold_reg <= 1'b0;
			oc_cnt_reg <= '0;
		end
		else
		begin
			ot_reg <= ~brown & (ot_s | (ot_reg & ~st_w1c_ot)); // [R20]
			oc_reg <= ~brown & (oc_event | (oc_reg & ~st_w1c_oc));
			oc_hold_reg <= ~brown & (oc_event | (oc_hold_reg & ~oc_restore));
			oc_cnt_reg <= (!oc_hold_reg || oc_chk) ? '0 :
				oc_cnt_reg + CW'(1); // [R21]
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Overcurrent recovery and brownout both restore the defaults.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg <= haptic_pkg::MODE_RST;
			offs_reg <= haptic_pkg::OFFS_RST;
			ctrl_reg <= haptic_pkg::CTRL_RST;
			rtp_reg <= haptic_pkg::RTP_RST;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			if (ctl_clr)
			begin
				mode_reg <= haptic_pkg::MODE_RST;
				offs_reg <= haptic_pkg::OFFS_RST; // [R2]
				ctrl_reg <= haptic_pkg::CTRL_RST;
				rtp_reg <= haptic_pkg::RTP_RST;
			end
			else
			begin
				if (wr && hit_md)
					mode_reg <= pwdata[3:0];
				if (wr && hit_of)
					offs_reg <= pwdata;
				if (wr && hit_ct)
					ctrl_reg <= pwdata[15:0];
				if (wr && hit_rt)
					rtp_reg <= pwdata[7:0];
			end
			if (setup)
				prdata_reg <= rd_word;
		end
	end

	// ------------------------------------------------------------
	// Fire bit
	// ------------------------------------------------------------
	logic fire_next;
	logic seq_done;
	wire edge_set = m_edge & trig_rise & ~fire_reg;
	wire edge_clr = m_edge & trig_rise & fire_reg;

	// A pin set beats a software clear in the same cycle.
	always_comb
	begin
		fire_next = fire_reg;
		if (halt || !m_lib)
			fire_next = 1'b0;
		else if (m_level)
			fire_next = trig_s; // [R15]
		else if (edge_set)
			fire_next = 1'b1; // [R11]
		else if (edge_clr)
			fire_next = 1'b0; // [R12]
		else if (fire_wr)
			fire_next = pwdata[0]; // [R10]
		else if (seq_done)
			fire_next = 1'b0;
	end

	// In edge mode a falling trigger edge never reaches the fire logic. [R13]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fire_reg <= 1'b0;
			fire_d_reg <= 1'b0;
		end
		else
		begin
			fire_reg <= fire_next;
			fire_d_reg <= fire_reg;
		end
	end

	wire fire_rise = fire_reg & ~fire_d_reg;
	assign seq_start = fire_rise;

	// ------------------------------------------------------------
	// Library step timing
	// ------------------------------------------------------------
	haptic_pkg::play_e state_next;
	haptic_pkg::lib_step_s step_reg;
	haptic_pkg::lib_step_s step_next;
	logic [8:0] el_reg;
	logic [8:0] el_next;
	logic [8:0] dur_reg;
	logic [8:0] dur_next;
	logic signed [7:0] start_reg;
	logic signed [7:0] start_next;
	logic signed [7:0] amp_reg;
	logic signed [7:0] amp_next;
	logic signed [7:0] seg_ofs;
	logic [CW-1:0] tick_cnt_reg;

	// The peaks of the waveform pick which offset stretches the step.
	always_comb
	begin
		seg_ofs = 8'sh00;
		if (lib_step.amp > 0 && lib_step.amp == lib_step.peak_pos)
			seg_ofs = $signed(offs_reg[7:0]); // [R3]
		else if (lib_step.amp < 0 && lib_step.amp == lib_step.peak_neg)
			seg_ofs = $signed(offs_reg[31:24]); // [R3]
		else if (lib_step.amp > 0)
			seg_ofs = $signed(offs_reg[15:8]);
		else if (lib_step.amp < 0)
			seg_ofs = $signed(offs_reg[23:16]);
	end

	// Offsets only ever reach the library path. [R1] [R2]
	wire signed [9:0] adj_sum = $signed({2'b00, lib_step.dur}) +
		$signed({{2{seg_ofs[7]}}, seg_ofs});
	wire [8:0] adj_dur = (adj_sum <= 0) ? 9'h000 : adj_sum[8:0];
	wire [CW-1:0] tick_lim = ctrl_reg[haptic_pkg::CT_FAST_BIT] ?
		CW'(STEP_FAST_CYC - 1) : CW'(STEP_SLOW_CYC - 1);
	wire hold = state_reg == haptic_pkg::PLAY_HOLD;
	wire tick = hold & (tick_cnt_reg == tick_lim); // [R5]
	wire step_end = tick & (el_reg + 9'h001 == dur_reg);
	assign lib_ready = state_reg == haptic_pkg::PLAY_FETCH;

	// Ramps spread the endpoint difference over the stretched time.
	wire signed [8:0] ramp_diff = $signed({step_reg.amp[7], step_reg.amp})
		- $signed({start_reg[7], start_reg});
	wire signed [18:0] ramp_prod = ramp_diff * $signed({1'b0, el_reg});
	wire [8:0] dur_safe = (dur_reg == 9'h000) ? 9'h001 : dur_reg;
	wire signed [18:0] ramp_quo = ramp_prod / $signed({10'h000, dur_safe});
	wire signed [7:0] lib_out = step_reg.ramp ?
		8'(start_reg + ramp_quo[7:0]) : step_reg.amp; // [R4]

	// Step sequencing; clearing the fire bit cancels at once.
	always_comb
	begin
		state_next = state_reg;
		step_next = step_reg;
		el_next = el_reg;
		dur_next = dur_reg;
		start_next = start_reg;
		amp_next = amp_reg;
		seq_done = 1'b0;
		case (state_reg)
			haptic_pkg::PLAY_IDLE:
				if (fire_rise)
					state_next = haptic_pkg::PLAY_FETCH;
			haptic_pkg::PLAY_FETCH:
				if (lib_valid)
				begin
					step_next = lib_step;
					start_next = amp_reg;
					el_next = 9'h000;
					dur_next = adj_dur; // [R2]
					if (adj_dur != 9'h000)
						state_next = haptic_pkg::PLAY_HOLD;
					else
					begin
						amp_next = lib_step.amp;
						seq_done = lib_step.last;
						if (lib_step.last)
							state_next = haptic_pkg::PLAY_IDLE;
					end
				end
			haptic_pkg::PLAY_HOLD:
				if (tick)
				begin
					el_next = el_reg + 9'h001;
					if (step_end)
					begin
						amp_next = step_reg.amp;
						seq_done = step_reg.last;
						state_next = step_reg.last ? haptic_pkg::PLAY_IDLE :
							haptic_pkg::PLAY_FETCH;
					end
				end
			default:
				state_next = haptic_pkg::PLAY_IDLE;
		endcase
		if (!fire_reg || halt)
			state_next = haptic_pkg::PLAY_IDLE; // [R10]
		if (state_next == haptic_pkg::PLAY_IDLE)
			amp_next = 8'sh00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= haptic_pkg::PLAY_IDLE;
			step_reg <= '0;
			el_reg <= 9'h000;
			dur_reg <= 9'h000;
			start_reg <= 8'sh00;
			amp_reg <= 8'sh00;
			tick_cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			step_reg <= step_next;
			el_reg <= el_next;
			dur_reg <= dur_next;
			start_reg <= start_next;
			amp_reg <= amp_next;
			tick_cnt_reg <= (!hold || tick) ? '0 : tick_cnt_reg + CW'(1);
		end
	end

	// ------------------------------------------------------------
	// Drive selection
	// ------------------------------------------------------------
	haptic_pkg::drive_s drive_next;
	wire [7:0] ng_thr = 8'(ctrl_reg[haptic_pkg::CT_NG_LSB +: 2] *
		haptic_pkg::NG_STEP);
	wire [7:0] pwm_gated = (pwm_level < ng_thr) ? 8'h00 : pwm_level;

	// Continuous modes drive whenever selected and not halted.
	always_comb
	begin
		drive_next = '0;
		drive_next.open_loop = ctrl_reg[haptic_pkg::CT_OL_BIT]; // [R8]
		drive_next.period = ctrl_reg[haptic_pkg::CT_PER_LSB +: 7]; // [R8]
		if (!halt)
		begin
			if (m_rtp)
			begin
				drive_next.active = 1'b1; // [R7] [R9]
				drive_next.amp = rtp_reg; // [R6]
			end
			else if (m_pwm)
			begin
				drive_next.active = 1'b1; // [R9]
				drive_next.amp = pwm_gated; // [R17]
			end
			else if (m_lib)
			begin
				drive_next.active = hold;
				drive_next.amp = hold ? lib_out : 8'h00;
			end
		end
	end

	logic [CW-1:0] wd_cnt_reg;
	logic wd_fire_reg;
	wire wd_hit = wd_cnt_reg == CW'(WDOG_CYC - 1);
	assign drive = drive_reg;
	assign serial_engine_reset = wd_fire_reg;

	// Supply capture, drive register and serial engine watchdog.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drive_reg <= '0;
			supply_reg <= 8'h00;
			wd_cnt_reg <= '0;
			wd_fire_reg <= 1'b0;
		end
		else
		begin
			drive_reg <= drive_next;
			if (brown)
				supply_reg <= 8'h00;
			else if (supply_valid && drive_reg.active)
				supply_reg <= supply_code; // [R18]
			if (standby || !serial_busy || serial_activity || wd_hit)
				wd_cnt_reg <= '0; // [R19]
			else
				wd_cnt_reg <= wd_cnt_reg + CW'(1);
			wd_fire_reg <= wd_hit & ~standby & serial_busy &
				~serial_activity; // [R19]
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence sw_clear_s;
		fire_wr && !pwdata[0] && fire_reg && !halt && !m_level &&
			!edge_set && !edge_clr;
	endsequence
	sequence cancel_s;
		!fire_reg ##1 state_reg == haptic_pkg::PLAY_IDLE;
	endsequence

	sw_cancel_a: assert property (sw_clear_s |=> cancel_s) // [R10]
		else $error("Software clear did not cancel playback.");
	edge_set_a: assert property (edge_set && !halt |=> fire_reg) // [R11]
		else $error("Rising trigger edge did not set fire.");
	edge_cancel_a: assert property (edge_clr && !halt |=> !fire_reg) // [R12]
		else $error("Second rising edge did not cancel.");
	edge_fall_a: assert property (m_edge && trig_fall && fire_reg &&
		!halt && !fire_wr && !seq_done |=> fire_reg) // [R13]
		else $error("Falling trigger edge changed fire.");
	level_a: assert property (m_level && !halt |=>
		fire_reg == $past(trig_s)) // [R15]
		else $error("Level mode fire does not follow pin.");
	rtp_pass_a: assert property (m_rtp && !halt |=>
		drive_reg.active && drive_reg.amp == $past(rtp_reg)) // [R6]
		else $error("Real-time amplitude not passed to drive.");
	cont_stop_a: assert property (standby |=> !drive_reg.active) // [R9]
		else $error("Drive active in standby.");
	gate_a: assert property (m_pwm && !halt && pwm_level < ng_thr |=>
		drive_reg.amp == 8'h00) // [R17]
		else $error("Noise gate let a small level through.");
	stretch_a: assert property (lib_ready && lib_valid && fire_reg &&
		!halt && adj_dur != 9'h000 |=> hold && dur_reg == $past(adj_dur)) // [R2]
		else $error("Stretched step time not loaded.");
	wdog_a: assert property (wd_hit && !standby && serial_busy &&
		!serial_activity |=> serial_engine_reset ##1
		!serial_engine_reset) // [R19]
		else $error("Watchdog reset pulse missing.");
	wdog_stby_a: assert property (standby |=> !serial_engine_reset) // [R19]
		else $error("Watchdog fired in standby.");
	oc_a: assert property (oc_event |=> oc_reg && shutdown) // [R21]
		else $error("Overcurrent not latched.");
endmodule

// ---- sim/lib_source.sv ----
// Partner model that offers library waveform steps to the block.
`timescale 1ns/1ns
module lib_source
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Step handshake.
	input wire logic seq_start,
	input wire logic lib_ready,
	output logic lib_valid,
	output haptic_pkg::lib_step_s lib_step
);
	// One held step of 20 ticks at the waveform's positive peak.
	// A step only counts once the block takes it.
	logic [33:0] step_val;
	logic [33:0] idle_pat;
	assign step_val = {8'h28, 8'h14, 1'b0, 1'b1, 8'h28, 8'h00};
	// Idle pattern flips every cycle, so a stale step is never mistaken.
	assign lib_step = lib_valid ? step_val : idle_pat;

	// Offer the step at each sequence start and drop it once taken.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lib_valid <= 1'b0;
			idle_pat <= 34'h0_0000_0000;
		end
		else
		begin
			idle_pat <= ~idle_pat;
			if (seq_start)
				lib_valid <= 1'b1;
			else if (lib_ready)
				lib_valid <= 1'b0;
		end
	end
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench of the haptic playback trigger control block.
`timescale 1ns/1ns
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic trig = 1'b0;
	logic hot = 1'b0;
	logic shorted = 1'b0;
	logic [7:0] pwm_level = 8'h00;
	logic [7:0] supply_code = 8'h00;
	logic supply_valid = 1'b0;
	logic serial_busy = 1'b0;
	logic brown_n = 1'b1;
	logic activity = 1'b0;
	logic lib_valid;
	logic lib_ready;
	logic seq_start;
	logic wd_reset;
	logic shutdown;
	haptic_pkg::lib_step_s lib_step;
	haptic_pkg::drive_s drive;
	logic [31:0] rdata;
	logic rerr;
	int n_fail = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_wrst = 0;

	// Shortened counts keep the run brief.
	haptic_playback_trigger_control #(.STEP_SLOW_CYC(50),
		.STEP_FAST_CYC(10), .WDOG_CYC(100), .OC_CHECK_CYC(20))
		i_haptic_playback_trigger_control (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .input_trigger_pin(trig), .over_temp_pin(hot),
		.short_detect_pin(shorted), .brownout_n_pin(brown_n),
		.lib_valid(lib_valid), .lib_step(lib_step), .lib_ready(lib_ready),
		.seq_start(seq_start), .pwm_level(pwm_level),
		.supply_code(supply_code), .supply_valid(supply_valid),
		.serial_busy(serial_busy), .serial_activity(activity),
		.serial_engine_reset(wd_reset), .drive(drive), .shutdown(shutdown));
	lib_source i_lib_source (.pclk(pclk), .presetn(presetn),
		.seq_start(seq_start), .lib_ready(lib_ready),
		.lib_valid(lib_valid), .lib_step(lib_step));

	// Clock and pulse counters.
	always #4 pclk = ~pclk;
	always @(posedge pclk)
	begin
		n_start <= n_start + int'(seq_start);
		n_wrst <= n_wrst + int'(wd_reset);
	end

	// ------------------------------------------------------------
	// Bus and comparison tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Returns at an edge; outputs read here still show the settled values.
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Waits for pready with no limit of its own; the watchdog ends a hang.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdata, e);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(haptic_pkg::OFF_OFFS, 32'h0000_0000);
		rd(haptic_pkg::OFF_CTRL, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h0000_0001);
		$display("test reset done");
	endtask
	task automatic t_cont;
		wr(haptic_pkg::OFF_OFFS, 32'h7f7f_7f7f);
		wr(haptic_pkg::OFF_RTP, 32'h0000_005a);
		wr(haptic_pkg::OFF_MODE, 32'h0000_0005);
		cyc(3);
		chk({15'h0, drive}, {15'h0, 1'b1, 8'h5a, 8'h00});
		supply_code <= 8'h77;
		supply_valid <= 1'b1;
		cyc(1);
		supply_valid <= 1'b0;
		rd(haptic_pkg::OFF_SUPPLY, 32'h0000_0077);
		wr(haptic_pkg::OFF_CTRL, 32'h0000_1202);
		cyc(3);
		chk({15'h0, drive}, {15'h0, 1'b1, 8'h5a, 8'h92});
		wr(haptic_pkg::OFF_MODE, 32'h0000_000d);
		cyc(3);
		chk({31'h0, drive.active}, 32'h0000_0000);
		wr(haptic_pkg::OFF_CTRL, 32'h0000_0004);
		pwm_level <= 8'h0f;
		wr(haptic_pkg::OFF_MODE, 32'h0000_0003);
		cyc(3);
		chk({24'h0, drive.amp}, 32'h0000_0000);
		pwm_level <= 8'h20;
		cyc(3);
		chk({24'h0, drive.amp}, 32'h0000_0020);
		shorted <= 1'b1;
		cyc(4);
		chk({31'h0, shutdown}, 32'h0000_0001);
		rd(haptic_pkg::OFF_STATUS, 32'h0000_0002);
		shorted <= 1'b0;
		cyc(50);
		rd(haptic_pkg::OFF_MODE, 32'h0000_0008);
		$display("test continuous modes done");
	endtask
	task automatic t_fire;
		int base;
		wr(haptic_pkg::OFF_OFFS, 32'h0000_00f6);
		wr(haptic_pkg::OFF_CTRL, 32'h0000_0001);
		wr(haptic_pkg::OFF_MODE, 32'h0000_0000);
		wr(haptic_pkg::OFF_FIRE, 32'h0000_0001);
		cyc(150);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0000);
		wr(haptic_pkg::OFF_OFFS, 32'h0000_0000);
		wr(haptic_pkg::OFF_FIRE, 32'h0000_0001);
		cyc(150);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0001);
		wr(haptic_pkg::OFF_FIRE, 32'h0000_0000);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0000);
		wr(haptic_pkg::OFF_CTRL, 32'h0000_0000);
		wr(haptic_pkg::OFF_MODE, 32'h0000_0001);
		base = n_start;
		trig <= 1'b1;
		cyc(130);
		trig <= 1'b0;
		cyc(5);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0001);
		chk(n_start - base, 32'h0000_0001);
		trig <= 1'b1;
		cyc(130);
		trig <= 1'b0;
		cyc(5);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0000);
		wr(haptic_pkg::OFF_MODE, 32'h0000_0002);
		trig <= 1'b1;
		cyc(5);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0001);
		trig <= 1'b0;
		cyc(5);
		rd(haptic_pkg::OFF_FIRE, 32'h0000_0000);
		$display("test fire and trigger done");
	endtask
	task automatic t_guard;
		int base;
		wr(haptic_pkg::OFF_MODE, 32'h0000_0000);
		serial_busy <= 1'b1;
		base = n_wrst;
		cyc(110);
		chk(n_wrst - base, 32'h0000_0001);
		// Regular serial activity keeps the count from ever running out.
		base = n_wrst;
		repeat (3)
		begin
			cyc(49);
			activity <= 1'b1;
			cyc(1);
			activity <= 1'b0;
		end
		chk(n_wrst - base, 32'h0000_0000);
		wr(haptic_pkg::OFF_MODE, 32'h0000_0008);
		base = n_wrst;
		cyc(250);
		chk(n_wrst - base, 32'h0000_0000);
		serial_busy <= 1'b0;
		hot <= 1'b1;
		cyc(4);
		chk({31'h0, shutdown}, 32'h0000_0001);
		rd(haptic_pkg::OFF_STATUS, 32'h0000_0003);
		hot <= 1'b0;
		wr(haptic_pkg::OFF_STATUS, 32'h0000_0003);
		rd(haptic_pkg::OFF_STATUS, 32'h0000_0000);
		$display("test watchdog and protection done");
	endtask
	// A supply dip stops the drive and restores the real-time and mode register defaults.
	task automatic t_brown;
		wr(haptic_pkg::OFF_RTP, 32'h0000_0033);
		wr(haptic_pkg::OFF_MODE, 32'h0000_0005);
		brown_n <= 1'b0;
		cyc(4);
		chk({31'h0, drive.active}, 32'h0000_0000);
		brown_n <= 1'b1;
		cyc(3);
		rd(haptic_pkg::OFF_RTP, 32'h0000_0000);
		rd(haptic_pkg::OFF_MODE, 32'h0000_0008);
		$display("test brownout done");
	endtask

	// Single place where the run ends.
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog, sized well past the roughly 1300 cycles the tests need.
	initial
	begin
		#100000;
		n_fail++;
		close_out;
	end

	// Main sequence.
	initial
	begin
		cyc(3);
		presetn <= 1'b1;
		t_reset;
		t_cont;
		t_fire;
		t_guard;
		t_brown;
		close_out;
	end
endmodule
